// ===== include/ddr_sram_dq_consts.svh
// Purpose: Constants for the DDR SRAM data-bus turnaround block
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef DDR_SRAM_DQ_CONSTS_SVH
`define DDR_SRAM_DQ_CONSTS_SVH

// Data bus organizations
`define DQ_WIDTH_WIDE   36
`define DQ_WIDTH_NARROW 18

// Address width of the wide organization
`define ADDR_WIDTH_DEF  21

// Write-data clock pairs, one per half of the bus
`define LANE_COUNT      2

`endif

// ===== include/ddr_sram_dq_pkg.sv
// Purpose: Types for the DDR SRAM data-bus turnaround block
// Assumes: Nothing
// Notes:   Codes are one-hot
`default_nettype none

package ddr_sram_dq_pkg;

  // Operation sampled on one master-clock edge
  typedef enum logic [3:0] {
    OP_IDLE_WRITE = 4'h1,
    OP_IDLE_READ  = 4'h2,
    OP_WRITE      = 4'h4,
    OP_READ       = 4'h8
  } op_t;

  // Data-pin state for one cycle
  typedef enum logic [2:0] {
    PIN_TERM = 3'h1,
    PIN_LOW  = 3'h2,
    PIN_DATA = 3'h4
  } pin_state_t;

endpackage

`default_nettype wire

// ===== hw/ddr_sram_dq_turnaround_io.sv
// Purpose: Data-pin state, write capture and read output of a burst-of-2 DDR SRAM
// Assumes: Commands synchronous to clock; write clocks are the link domains
// Notes:   Complement clocks are modelled by the falling edge of each clock
//
// What this block does
// (RULE_01) load_n/read_write_sel decode to idle-write, idle-read, write or read.
// (RULE_02) Controller never follows a read directly with write or idle-write.
// (RULE_03) Prior cycle not read: write-side gives termination, read-side drives low.
// (RULE_04) Prior read: read-side keeps read data, write-side is undefined.
// (RULE_05) Two cycles after op, next op's side picks termination or low.
// (RULE_06) Write to read needs no idle cycles; one or two are typical.
// (RULE_07) Read to write needs two idle-read then three idle-write cycles minimum.
// (RULE_08) Termination turns off 2.5 cycles after last write beat.
// (RULE_09) Pins drive low one cycle before the first read beat.
// (RULE_10) Pins drive low one cycle after the last read beat.
// (RULE_11) Termination turns on one cycle before the first write beat.
// (RULE_12) Controller releases write data and terminates around the device low drive.
// (RULE_13) Controller drops termination and drives write data only after device terminates.
// (RULE_14) Without termination, pins stay low unless carrying own data.
// (RULE_15) Address and control are captured on master-clock rising edge.
// (RULE_16) Write clock pair 0 captures the lower data half on both edges.
// (RULE_17) Write clock pair 1 captures the upper data half on both edges.
// (RULE_18) Rising phase raises echo clock and starts the first read beat.
// (RULE_19) Falling phase lowers echo clock, starts second beat, updates read valid.
// (RULE_20) Echo clock rise follows a delayed copy of master rise.
// (RULE_21) Echo pair 0 goes with the lower half and read_valid0.
// (RULE_22) Echo pair 1 goes with upper half; read_valid1 wide, read_valid0 narrow.
// (RULE_23) read_write_sel high drops termination; low terminates with drivers off.
// (RULE_24) Read data appears three cycles after the read command.
// (RULE_25) A pipeline of past operations decides each data-pin state.
`include "ddr_sram_dq_consts.svh"
`default_nettype none

module ddr_sram_dq_turnaround_io #(
  parameter int DQ_WIDTH = `DQ_WIDTH_WIDE,
  parameter int ADDR_W   = `ADDR_WIDTH_DEF
) (
  // Master clock and reset
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  // Command pins
  input  wire logic                    load_n,
  input  wire logic                    read_write_sel,
  input  wire logic [ADDR_W-1:0]       sync_address,
  // Write-data clocks, one per bus half
  input  wire logic [1:0]              write_data_clock,
  // Data pins
  input  wire logic [DQ_WIDTH-1:0]     dq_in,
  output logic      [DQ_WIDTH-1:0]     dq_out,
  output logic                         dq_oe,
  output logic                         odt_enable,
  // Echo clocks and valid flags
  output logic      [1:0]              echo_clock,
  output logic      [1:0]              echo_clock_n,
  output logic                         read_valid0,
  output logic                         read_valid1,
  // Array side, read
  output logic                         read_strobe,
  output logic      [ADDR_W-1:0]       read_address,
  input  wire logic [2*DQ_WIDTH-1:0]   read_word,
  // Array side, write
  output logic                         write_strobe,
  output logic      [ADDR_W-1:0]       write_address,
  output logic      [2*DQ_WIDTH-1:0]   write_word
);

  localparam int HALF = DQ_WIDTH / 2;

  if ((DQ_WIDTH != `DQ_WIDTH_WIDE) && (DQ_WIDTH != `DQ_WIDTH_NARROW)) begin : g_bad_width
    $error("DQ_WIDTH must be 36 or 18");
  end

  // Command decode
  function automatic ddr_sram_dq_pkg::op_t decode_op(input logic ld_n, input logic rw);
    case ({ld_n, rw})
      2'b10:   decode_op = ddr_sram_dq_pkg::OP_IDLE_WRITE;
      2'b11:   decode_op = ddr_sram_dq_pkg::OP_IDLE_READ;
      2'b00:   decode_op = ddr_sram_dq_pkg::OP_WRITE;
      default: decode_op = ddr_sram_dq_pkg::OP_READ;
    endcase
  endfunction

  // True for read and idle-read
  function automatic logic read_side(input ddr_sram_dq_pkg::op_t op);
    read_side = (op == ddr_sram_dq_pkg::OP_IDLE_READ) || (op == ddr_sram_dq_pkg::OP_READ);
  endfunction

  // Operations seen one, two and three edges ago
  ddr_sram_dq_pkg::op_t       op_n1;
  ddr_sram_dq_pkg::op_t       op_n2;
  ddr_sram_dq_pkg::op_t       op_n3;
  ddr_sram_dq_pkg::pin_state_t pin_state;
  ddr_sram_dq_pkg::pin_state_t next_pin_state;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      op_n1 <= ddr_sram_dq_pkg::OP_IDLE_WRITE;
      op_n2 <= ddr_sram_dq_pkg::OP_IDLE_WRITE;
      op_n3 <= ddr_sram_dq_pkg::OP_IDLE_WRITE;
    end else begin
      op_n1 <= decode_op(load_n, read_write_sel); // RULE_01 RULE_15
      op_n2 <= op_n1; // RULE_25
      op_n3 <= op_n2; // RULE_25
    end
  end

  // Address capture
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      read_address  <= '0;
      write_address <= '0;
    end else begin
      read_address <= sync_address; // RULE_15
      if (!load_n && !read_write_sel) begin
        write_address <= sync_address; // RULE_15
      end
    end
  end

  assign read_strobe = (op_n1 == ddr_sram_dq_pkg::OP_READ);

  // Read data pipeline, array answers one cycle after read_strobe
  logic [2*DQ_WIDTH-1:0] rd_p2;
  logic [2*DQ_WIDTH-1:0] drive_word;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_p2 <= '0;
    end else begin
      if (op_n2 == ddr_sram_dq_pkg::OP_READ) begin
        rd_p2 <= read_word;
      end
    end
  end

  // Next data-pin state from the command history
  always_comb begin
    if (!read_side(op_n2)) begin
      next_pin_state = ddr_sram_dq_pkg::PIN_TERM; // RULE_03 RULE_05 RULE_08 RULE_11 RULE_23
    end else if (op_n3 == ddr_sram_dq_pkg::OP_READ) begin
      next_pin_state = ddr_sram_dq_pkg::PIN_DATA; // RULE_04 RULE_24
    end else begin
      next_pin_state = ddr_sram_dq_pkg::PIN_LOW; // RULE_09 RULE_10 RULE_23
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_state  <= ddr_sram_dq_pkg::PIN_TERM;
      drive_word <= '0;
    end else begin
      pin_state <= next_pin_state;
      case (next_pin_state)
        ddr_sram_dq_pkg::PIN_DATA: drive_word <= rd_p2; // RULE_24
        default:                   drive_word <= '0; // RULE_14
      endcase
    end
  end

  assign odt_enable = pin_state[0]; // RULE_23
  assign dq_oe      = !pin_state[0]; // RULE_14

  // Half-cycle output phase
  logic                echo_rise;
  logic                echo_fall;
  logic                valid_fall;
  logic [DQ_WIDTH-1:0] fall_beat;
  logic                echo_level;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      echo_rise <= 1'b0;
    end else begin
      echo_rise <= !echo_rise; // RULE_18 RULE_20
    end
  end

  always_ff @(negedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      echo_fall  <= 1'b0;
      valid_fall <= 1'b0;
      fall_beat  <= '0;
    end else begin
      echo_fall  <= echo_rise; // RULE_19
      valid_fall <= (pin_state == ddr_sram_dq_pkg::PIN_DATA); // RULE_19
      fall_beat  <= drive_word[2*DQ_WIDTH-1:DQ_WIDTH]; // RULE_19
    end
  end

  assign echo_level   = echo_rise ^ echo_fall;
  assign echo_clock   = {2{echo_level}}; // RULE_21 RULE_22
  assign echo_clock_n = {2{!echo_level}};
  assign dq_out       = clock ? drive_word[DQ_WIDTH-1:0] : fall_beat; // RULE_18 RULE_19
  assign read_valid0  = valid_fall; // RULE_21 RULE_22
  assign read_valid1  = (DQ_WIDTH == `DQ_WIDTH_WIDE) ? valid_fall : 1'b0; // RULE_22

  // Write capture, one domain per write-data clock
  for (genvar ln = 0; ln < `LANE_COUNT; ln++) begin : g_lane
    logic [HALF-1:0]   rise_beat;
    logic [2*HALF-1:0] word;
    logic              tgl;

    always_ff @(posedge write_data_clock[ln] or posedge sys_rst) begin
      if (sys_rst) begin
        rise_beat <= '0;
      end else begin
        rise_beat <= dq_in[ln*HALF +: HALF]; // RULE_16 RULE_17
      end
    end

    always_ff @(negedge write_data_clock[ln] or posedge sys_rst) begin
      if (sys_rst) begin
        word <= '0;
        tgl  <= 1'b0;
      end else begin
        word <= {dq_in[ln*HALF +: HALF], rise_beat}; // RULE_16 RULE_17
        tgl  <= !tgl;
      end
    end
  end

  // Toggle crossing into the master domain
  logic [1:0] tgl_s1;
  logic [1:0] tgl_s2;
  logic [1:0] tgl_s3;
  logic [1:0] lane_seen;
  logic [1:0] lane_arrive;
  logic [1:0] lane_any;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tgl_s1 <= '0;
      tgl_s2 <= '0;
      tgl_s3 <= '0;
    end else begin
      tgl_s1 <= {g_lane[1].tgl, g_lane[0].tgl};
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign lane_arrive = tgl_s2 ^ tgl_s3;
  assign lane_any    = lane_seen | lane_arrive;

  // Pair both halves into one array word
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lane_seen    <= '0;
      write_strobe <= 1'b0;
      write_word   <= '0;
    end else begin
      write_strobe <= &lane_any;
      if (&lane_any) begin
        lane_seen  <= '0;
        write_word <= {g_lane[1].word[2*HALF-1:HALF], g_lane[0].word[2*HALF-1:HALF],
                       g_lane[1].word[HALF-1:0], g_lane[0].word[HALF-1:0]};
      end else begin
        lane_seen <= lane_any;
      end
    end
  end

  // Checks
  chk_decode_read : // RULE_01
  assert property (@(posedge clock) disable iff (sys_rst)
    (!load_n && read_write_sel) |=> read_strobe)
    else $error("read command not decoded");

  chk_write_side_term : // RULE_03
  assert property (@(posedge clock) disable iff (sys_rst)
    (!read_write_sel) |-> ##3 (odt_enable && !dq_oe))
    else $error("write-side command did not terminate pins");

  chk_read_side_low : // RULE_23
  assert property (@(posedge clock) disable iff (sys_rst)
    (read_side(op_n2) && op_n3 != ddr_sram_dq_pkg::OP_READ)
      |=> (dq_oe && !odt_enable && drive_word == '0))
    else $error("read-side idle did not drive low");

  chk_read_latency : // RULE_24
  assert property (@(posedge clock) disable iff (sys_rst)
    (!load_n && read_write_sel) ##1 read_write_sel
      |-> ##3 (dq_oe && pin_state == ddr_sram_dq_pkg::PIN_DATA))
    else $error("read data not on pins three cycles after read");

  chk_low_before_read : // RULE_09
  assert property (@(posedge clock) disable iff (sys_rst)
    $rose(pin_state == ddr_sram_dq_pkg::PIN_DATA)
      |-> $past(pin_state == ddr_sram_dq_pkg::PIN_LOW))
    else $error("no low cycle before read data");

  chk_low_after_read : // RULE_10
  assert property (@(posedge clock) disable iff (sys_rst)
    $fell(pin_state == ddr_sram_dq_pkg::PIN_DATA)
      |-> (pin_state == ddr_sram_dq_pkg::PIN_LOW && dq_oe && drive_word == '0))
    else $error("no low cycle after read data");

  chk_low_means_zero : // RULE_14
  assert property (@(posedge clock) disable iff (sys_rst)
    (dq_oe && pin_state != ddr_sram_dq_pkg::PIN_DATA) |-> (drive_word == '0))
    else $error("driven pins not low outside read data");

  chk_valid_tracks : // RULE_19
  assert property (@(posedge clock) disable iff (sys_rst)
    ##1 (read_valid0 == $past(pin_state == ddr_sram_dq_pkg::PIN_DATA, 1)) or
        (read_valid0 == (pin_state == ddr_sram_dq_pkg::PIN_DATA)))
    else $error("read valid out of step with read data");

  chk_echo_phase : // RULE_18
  assert property (@(posedge clock) disable iff (sys_rst)
    ##1 (!echo_clock[0] && echo_clock_n[0] && echo_clock[1] == echo_clock[0]))
    else $error("echo clock not low before master rise");

endmodule

`default_nettype wire

// ===== verif/ctrl_model.sv
// Purpose: Controller-side write-data launcher for the turnaround block
// Assumes: Lane 1 lags lane 0 by a few ns
// Notes:   Link clocks stand still between bursts
`default_nettype none

module ctrl_model #(
  parameter int W = 36
) (
  // Link clocks and data pins
  output var logic [1:0]   write_data_clock,
  output var logic [W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    write_data_clock = 2'h0;
    dq_in = '0;
  end

  // One burst of two beats, link period 30 ns
  task automatic send(input logic [W-1:0] b1, input logic [W-1:0] b2);
    dq_in = b1;
    #3 write_data_clock[0] = 1'b1;
    #4 write_data_clock[1] = 1'b1;
    #4 dq_in = b2;
    #7 write_data_clock[0] = 1'b0;
    #4 write_data_clock[1] = 1'b0;
    #4 dq_in = '0;
  endtask
endmodule

`default_nettype wire

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the data-bus turnaround block
// Assumes: Wide organization, controller keeps the sequence rules
// Notes:   Driver notes expectations, monitors pop them
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] IW = 2'h2, IR = 2'h3, WR = 2'h0, RD = 2'h1;
  logic                       clock, sys_rst, load_n, read_write_sel;
  logic                       dq_oe, odt_enable, read_valid0, read_valid1;
  logic                       read_strobe, write_strobe;
  logic [20:0]                sync_address, read_address, write_address;
  logic [35:0]                dq_in, dq_out, beat1;
  logic [71:0]                read_word, write_word;
  logic [1:0]                 write_data_clock, echo_clock, echo_clock_n;
  logic [1:0]                 h [5];
  int                         mismatches, checked;
  ddr_sram_dq_pkg::pin_state_t pin_q[$], got, e;
  logic [71:0]                rd_q[$];
  logic [92:0]                wr_q[$];
  logic [20:0]                ad_q[$];

  ddr_sram_dq_turnaround_io DUT (.clock(clock), .sys_rst(sys_rst), .load_n(load_n),
    .read_write_sel(read_write_sel), .sync_address(sync_address),
    .write_data_clock(write_data_clock), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .odt_enable(odt_enable), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n),
    .read_valid0(read_valid0), .read_valid1(read_valid1), .read_strobe(read_strobe),
    .read_address(read_address), .read_word(read_word), .write_strobe(write_strobe),
    .write_address(write_address), .write_word(write_word));
  ctrl_model ctrl (.write_data_clock(write_data_clock), .dq_in(dq_in));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic cmp(input logic [95:0] g, input logic [95:0] x);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic conclude();
    $display("counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One command cycle with its expectations
  task automatic cmd(input logic [1:0] op);
    logic [35:0] b1, b2;
    @(posedge clock);
    #1;
    for (int i = 4; i > 0; i--) begin
      h[i] = h[i-1];
    end
    h[0] = op;
    {load_n, read_write_sel} = op;
    sync_address = 21'($urandom);
    read_word = {$urandom, $urandom, 8'($urandom)};
    if (op == RD) ad_q.push_back(sync_address);
    if (op == WR) begin
      b1 = {$urandom, 4'($urandom)};
      b2 = {$urandom, 4'($urandom)};
      wr_q.push_back({sync_address, b2, b1});
      fork
        ctrl.send(b1, b2);
      join_none
    end
    if (h[2] == RD) rd_q.push_back(read_word);
    if (!h[3][0]) pin_q.push_back(ddr_sram_dq_pkg::PIN_TERM);
    else if (h[4] == RD) pin_q.push_back(ddr_sram_dq_pkg::PIN_DATA);
    else pin_q.push_back(ddr_sram_dq_pkg::PIN_LOW);
  endtask

  task automatic run(input string name, input logic [1:0] ops[$]);
    foreach (ops[i]) begin
      cmd(ops[i]);
    end
    $display("test %s done", name);
  endtask

  always @(posedge clock) begin
    #2;
    if (!sys_rst) begin
      cmp({echo_clock, echo_clock_n}, 4'hC);
      beat1 = dq_out;
      if (pin_q.size() > 0) begin
        e = pin_q.pop_front();
        got = !dq_oe ? ddr_sram_dq_pkg::PIN_TERM :
              (dq_out === '0 ? ddr_sram_dq_pkg::PIN_LOW : ddr_sram_dq_pkg::PIN_DATA);
        cmp({odt_enable, got}, {e == ddr_sram_dq_pkg::PIN_TERM, e});
      end
      if (read_strobe === 1'b1) cmp(read_address, ad_q.pop_front());
      if (write_strobe === 1'b1) cmp({write_address, write_word}, wr_q.pop_front());
    end
  end

  always @(negedge clock) begin
    #1;
    if (!sys_rst) begin
      cmp({echo_clock, echo_clock_n}, 4'h3);
      if (read_valid0 === 1'b1) begin
        cmp(read_valid1, 1'b1);
        cmp({dq_out, beat1}, rd_q.pop_front());
      end
    end
  end

  initial begin
    void'($urandom(15030));
    {sys_rst, load_n, read_write_sel} = 3'h6;
    sync_address = 21'h0;
    read_word = 72'h0;
    foreach (h[i]) begin
      h[i] = IW;
    end
    repeat (6) @(posedge clock);
    @(negedge clock);
    #0.5 sys_rst = 1'b0;
    run("turnaround", '{WR, RD, RD, IR, IR, IW, IW, IW, IW, WR, IW, IW, IW, IW, IW, IW,
      IW, IW, IR, RD, IR, IR, IR, IW, IW, IW, IW});
    for (int t = 0; t < 6; t++) begin
      repeat ($urandom_range(1, 4)) cmd($urandom_range(0, 1) ? RD : IR);
      run("random burst", '{IR, IR, IW, IW, IW, WR, IW, IW, IW, IW, IW, IW, IW, IW});
    end
    for (int i = 0; i < 40 && rd_q.size() + wr_q.size() + ad_q.size() > 0; i++) begin
      cmd(IR);
    end
    cmp(rd_q.size() + wr_q.size() + ad_q.size(), 0);
    $display("test drain done");
    conclude();
  end
endmodule

`default_nettype wire
